// file: src/sclc_consts.svh
// sclc_consts.svh: offsets, field positions, reset values and timing
// counts of the serial link clocking and lock control block.
// assumes inclusion by bare name from the top module and the property checker.
`ifndef SCLC_CONSTS_SVH
`define SCLC_CONSTS_SVH

// ----------------------------------------------------------------------
// attribute register offsets
// ----------------------------------------------------------------------
`define SCLC_ADDR_W          4
`define SCLC_REG_W           8
`define SCLC_OFS_SWING       4'h0
`define SCLC_OFS_EMPHASIS    4'h1
`define SCLC_OFS_EQUALIZER   4'h2
`define SCLC_OFS_CONTROL     4'h3
`define SCLC_OFS_STATUS      4'h4

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SCLC_CTRL_RX_SWAP    0
`define SCLC_STAT_LOCKED     0
`define SCLC_STAT_ACQUIRING  1
`define SCLC_STAT_FORCED     2
`define SCLC_STAT_LEVEL_LSB  4
`define SCLC_CONTROL_RESET   8'h00

// ----------------------------------------------------------------------
// lock counts, in transitions and serial bit periods, and the largest ratio
// ----------------------------------------------------------------------
`define SCLC_LOCK_TRANSITIONS 5000
`define SCLC_MISS_LIMIT       75
`define SCLC_MAX_FACTOR       40

`endif

// file: src/sclc_pkg.sv
// sclc_pkg.sv: types of the serial link clocking and lock control block.
// assumes sclc_consts.svh is on the include path.
`default_nettype none

package sclc_pkg;

   // one-hot serial/parallel ratio
   typedef enum logic [4:0] {
      SCLC_MODE_X10 = 5'h01,
      SCLC_MODE_X16 = 5'h02,
      SCLC_MODE_X20 = 5'h04,
      SCLC_MODE_X32 = 5'h08,
      SCLC_MODE_X40 = 5'h10
   } sclc_mode_t;

   // where the receive recovery loop takes its timing from
   typedef enum logic [2:0] {
      SCLC_LK_REF     = 3'h1,
      SCLC_LK_ACQUIRE = 3'h2,
      SCLC_LK_DATA    = 3'h4
   } sclc_lock_t;

endpackage

`default_nettype wire

// file: src/sclc_top.sv
// sclc_top.sv: digital clocking, polarity, lock and attribute control of
// a serial transceiver; one serial bit moves per clk edge.
// assumes clk is the local reference and the fabric transmit clock is
// frequency locked to it, so both sides share the one clk.
//
// Summary of operation
// - A word of 10, 16, 20, 32 or 40 bits leaves per word period.
// - The recovered clock runs at 1/10..1/40 of the serial bit rate.
// - Transmit outputs swap while the fabric raises tx_invert_select.
// - A control bit swaps the positive and negative receive inputs.
// - Lock follows incoming data when present, else the reference.
// - rx_lock_source_select forces lock to the local reference.
// - Under forced lock, data phase is ignored and framing is local.
// - Lock survives up to 75 bit periods without a transition.
// - Transmit words pass a FIFO written from the fabric side.
// - Swing and emphasis load from configuration, then the bus.
// - Equalization loads from configuration or the bus.
//
// Local design decisions: the address map and strobed register access.
`include "sclc_consts.svh"
`default_nettype none

module sclc_top import sclc_pkg::*; #(
   parameter int WORD_W           = `SCLC_MAX_FACTOR,
   parameter int FIFO_DEPTH       = 4,
   parameter int LOCK_TRANSITIONS = `SCLC_LOCK_TRANSITIONS,
   parameter int MISS_LIMIT       = `SCLC_MISS_LIMIT
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    reset,
   // mode and configuration attributes
   input  wire logic [2:0]              modeSelect,
   input  wire logic [`SCLC_REG_W-1:0]  cfgSwing,
   input  wire logic [`SCLC_REG_W-1:0]  cfgEmphasis,
   input  wire logic [`SCLC_REG_W-1:0]  cfgEqualizer,
   // attribute programming bus
   input  wire logic [`SCLC_ADDR_W-1:0] attrAddr,
   input  wire logic [`SCLC_REG_W-1:0]  attrWrData,
   input  wire logic                    attrWrite,
   input  wire logic                    attrRead,
   output logic      [`SCLC_REG_W-1:0]  attrRdData,
   // analog settings driven to the line drivers and the receive equalizer
   output logic      [`SCLC_REG_W-1:0]  txSwing,
   output logic      [`SCLC_REG_W-1:0]  txEmphasis,
   output logic      [`SCLC_REG_W-1:0]  rx_equalizer_setting,
   // fabric transmit side
   input  wire logic [WORD_W-1:0]       txData,
   input  wire logic                    txValid,
   output logic                         txReady,
   input  wire logic                    tx_invert_select,
   // fabric receive side
   input  wire logic                    rx_lock_source_select,
   output logic      [WORD_W-1:0]       rxData,
   output logic                         rxValid,
   output logic                         rx_recovered_clock,
   output logic                         rxLockedToData,
   // serial pins
   output logic                         tx_serial_pos,
   output logic                         tx_serial_neg,
   input  wire logic                    rx_serial_pos,
   input  wire logic                    rx_serial_neg
);

   localparam int PTR_W  = $clog2(FIFO_DEPTH);
   localparam int LVL_W  = PTR_W + 1;
   localparam int TCNT_W = $clog2(LOCK_TRANSITIONS + 1);
   localparam int MCNT_W = $clog2(MISS_LIMIT + 2);

   if (WORD_W != `SCLC_MAX_FACTOR) begin : g_bad_word
      $error("sclc_top: WORD_W must equal the largest ratio");
   end
   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo
      $error("sclc_top: FIFO_DEPTH must be a power of two, >= 2");
   end
   if (LOCK_TRANSITIONS < 2 || MISS_LIMIT < 1) begin : g_bad_lock
      $error("sclc_top: lock counts out of range");
   end

   typedef struct packed {
      logic [FIFO_DEPTH-1:0][WORD_W-1:0] fifoMem;
      logic [PTR_W-1:0]                  fifoWr;
      logic [PTR_W-1:0]                  fifoRd;
      logic [LVL_W-1:0]                  fifoLevel;
      logic [WORD_W-1:0]                 txShift;
      logic [5:0]                        txBitCnt;
      logic                              txInvert;
      logic                              txPos;
      logic                              txNeg;
      logic [WORD_W-1:0]                 rxShift;
      logic [5:0]                        rxBitCnt;
      logic [WORD_W-1:0]                 rxWord;
      logic                              rxWordValid;
      logic                              recClk;
      logic                              rxPrevBit;
      logic [TCNT_W-1:0]                 transCnt;
      logic [MCNT_W-1:0]                 missCnt;
      sclc_lock_t                        lockState;
      logic [`SCLC_REG_W-1:0]            swing;
      logic [`SCLC_REG_W-1:0]            emphasis;
      logic [`SCLC_REG_W-1:0]            equalizer;
      logic [`SCLC_REG_W-1:0]            control;
      logic [`SCLC_REG_W-1:0]            rdData;
   } sclc_state_t;

   sclc_state_t q;
   sclc_state_t d;

   // ---------------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------------
   sclc_mode_t mode;
   logic [5:0] factor;

   always_comb begin
      case (modeSelect)
         3'h0:    mode = SCLC_MODE_X10;
         3'h1:    mode = SCLC_MODE_X16;
         3'h3:    mode = SCLC_MODE_X32;
         3'h4:    mode = SCLC_MODE_X40;
         default: mode = SCLC_MODE_X20;
      endcase
      case (mode)
         SCLC_MODE_X10: factor = 6'h0a;
         SCLC_MODE_X16: factor = 6'h10;
         SCLC_MODE_X32: factor = 6'h20;
         SCLC_MODE_X40: factor = 6'h28;
         default:       factor = 6'h14;
      endcase
   end

   // ---------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------
   logic fifoPush;
   logic fifoPop;
   logic txWordEnd;
   logic rxBit;
   logic rxEdge;
   logic forceRef;
   logic rxWordEnd;

   always_comb begin
      d = q;

      // transmit fifo; full stalls the fabric through txReady
      txReady   = (q.fifoLevel != LVL_W'(FIFO_DEPTH));
      // compare with >= so a shorter ratio chosen mid-word ends it at once
      // instead of letting the count run round its full range
      txWordEnd = (q.txBitCnt >= factor - 6'h01);
      fifoPush  = txValid && txReady;
      fifoPop   = txWordEnd && (q.fifoLevel != '0);
      if (fifoPush) begin
         d.fifoMem[q.fifoWr] = txData;
         d.fifoWr            = q.fifoWr + PTR_W'(1);
      end
      if (fifoPop)
         d.fifoRd = q.fifoRd + PTR_W'(1);
      if (fifoPush && !fifoPop)
         d.fifoLevel = q.fifoLevel + LVL_W'(1);
      else if (fifoPop && !fifoPush)
         d.fifoLevel = q.fifoLevel - LVL_W'(1);

      // serializer: lsb first, idle zeros while the fifo is empty
      if (txWordEnd) begin
         d.txBitCnt = '0;
         d.txShift  = fifoPop ? q.fifoMem[q.fifoRd] : '0;
      end else begin
         d.txBitCnt = q.txBitCnt + 6'h01;
         d.txShift  = q.txShift >> 1;
      end
      d.txInvert = tx_invert_select;
      d.txPos    = q.txShift[0] ^ q.txInvert;
      d.txNeg    = ~(q.txShift[0] ^ q.txInvert);

      // receive pair swap and transition detection
      // a crossed pair reads as inverted data on the positive leg, so the
      // swap takes the negative leg as the true bit
      rxBit    = q.control[`SCLC_CTRL_RX_SWAP] ? rx_serial_neg
                                               : rx_serial_pos;
      rxEdge   = (rxBit != q.rxPrevBit);
      forceRef = rx_lock_source_select;
      d.rxPrevBit = rxBit;

      // consecutive bit periods with no transition, saturating
      if (rxEdge)
         d.missCnt = '0;
      else if (q.missCnt != MCNT_W'(MISS_LIMIT + 1))
         d.missCnt = q.missCnt + MCNT_W'(1);

      // lock source machine
      case (q.lockState)
         SCLC_LK_REF: begin
            d.transCnt = '0;
            if (!forceRef && rxEdge) begin
               d.lockState = SCLC_LK_ACQUIRE;
               d.transCnt  = TCNT_W'(1);
            end
         end
         SCLC_LK_ACQUIRE: begin
            if (forceRef || q.missCnt > MCNT_W'(MISS_LIMIT)) begin
               d.lockState = SCLC_LK_REF;
            end else if (rxEdge) begin
               d.transCnt = q.transCnt + TCNT_W'(1);
               if (q.transCnt == TCNT_W'(LOCK_TRANSITIONS - 1))
                  d.lockState = SCLC_LK_DATA;
            end
         end
         SCLC_LK_DATA: begin
            if (forceRef)
               d.lockState = SCLC_LK_REF;
            else if (q.missCnt > MCNT_W'(MISS_LIMIT))
               d.lockState = SCLC_LK_REF;
         end
         default: d.lockState = SCLC_LK_REF;
      endcase

      // deserializer framing: local count, realigned to the data only at
      // the moment lock moves onto it; forced lock never realigns
      rxWordEnd     = (q.rxBitCnt >= factor - 6'h01);
      d.rxShift     = {rxBit, q.rxShift[WORD_W-1:1]};
      d.rxWordValid = 1'b0;
      if (q.lockState != SCLC_LK_DATA && d.lockState == SCLC_LK_DATA) begin
         d.rxBitCnt = '0;
      end else if (rxWordEnd) begin
         d.rxBitCnt    = '0;
         d.rxWord      = d.rxShift >> (6'(WORD_W) - factor);
         d.rxWordValid = 1'b1;
      end else begin
         d.rxBitCnt = q.rxBitCnt + 6'h01;
      end
      d.recClk = (d.rxBitCnt < (factor >> 1));

      // attribute bus writes
      if (attrWrite) begin
         if (attrAddr == `SCLC_OFS_SWING)
            d.swing = attrWrData;
         else if (attrAddr == `SCLC_OFS_EMPHASIS)
            d.emphasis = attrWrData;
         else if (attrAddr == `SCLC_OFS_EQUALIZER)
            d.equalizer = attrWrData;
         else if (attrAddr == `SCLC_OFS_CONTROL)
            d.control = attrWrData;
      end

      // attribute bus reads; unmapped offsets answer zero
      d.rdData = '0;
      if (attrRead) begin
         if (attrAddr == `SCLC_OFS_SWING)
            d.rdData = q.swing;
         else if (attrAddr == `SCLC_OFS_EMPHASIS)
            d.rdData = q.emphasis;
         else if (attrAddr == `SCLC_OFS_EQUALIZER)
            d.rdData = q.equalizer;
         else if (attrAddr == `SCLC_OFS_CONTROL)
            d.rdData = q.control;
         else if (attrAddr == `SCLC_OFS_STATUS) begin
            d.rdData[`SCLC_STAT_LOCKED]    = (q.lockState == SCLC_LK_DATA);
            d.rdData[`SCLC_STAT_ACQUIRING] = (q.lockState == SCLC_LK_ACQUIRE);
            d.rdData[`SCLC_STAT_FORCED]    = forceRef;
            d.rdData[`SCLC_REG_W-1:`SCLC_STAT_LEVEL_LSB] =
               (`SCLC_REG_W-`SCLC_STAT_LEVEL_LSB)'(q.fifoLevel);
         end
      end
   end

   // ---------------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------------
   // the analog attributes reload from configuration on every reset, so
   // a reset undoes run-time tuning done over the bus
   always_ff @(posedge clk) begin
      if (reset) begin
         q           <= '0;
         q.lockState <= SCLC_LK_REF;
         q.recClk    <= 1'b1;
         q.txNeg     <= 1'b1;
         q.control   <= `SCLC_CONTROL_RESET;
         q.swing     <= cfgSwing;
         q.emphasis  <= cfgEmphasis;
         q.equalizer <= cfgEqualizer;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------
   assign attrRdData           = q.rdData;
   assign txSwing              = q.swing;
   assign txEmphasis           = q.emphasis;
   assign rx_equalizer_setting = q.equalizer;
   assign rxData               = q.rxWord;
   assign rxValid              = q.rxWordValid;
   assign rx_recovered_clock   = q.recClk;
   assign rxLockedToData       = (q.lockState == SCLC_LK_DATA);
   assign tx_serial_pos        = q.txPos;
   assign tx_serial_neg        = q.txNeg;

endmodule

`default_nettype wire

// file: sim/sclc_top_props.sv
// sclc_top_props.sv: port checks of sclc_top, bound to it below.
// assumes one clk domain with synchronous active-high reset.
`include "sclc_consts.svh"
`default_nettype none

module sclc_top_props #(
   parameter int MISS_LIMIT = `SCLC_MISS_LIMIT
) (
   // clock and reset
   input wire logic                    clk,
   input wire logic                    reset,
   // attribute bus
   input wire logic [`SCLC_ADDR_W-1:0] attrAddr,
   input wire logic [`SCLC_REG_W-1:0]  attrWrData,
   input wire logic                    attrWrite,
   input wire logic                    attrRead,
   input wire logic [`SCLC_REG_W-1:0]  attrRdData,
   input wire logic [`SCLC_REG_W-1:0]  txSwing,
   input wire logic [`SCLC_REG_W-1:0]  rx_equalizer_setting,
   // lock and serial
   input wire logic                    rx_lock_source_select,
   input wire logic                    rxValid,
   input wire logic                    rxLockedToData,
   input wire logic                    tx_serial_pos,
   input wire logic                    tx_serial_neg,
   input wire logic                    rx_serial_pos
);
   // ---
   // bit periods since the last receive transition
   // ---
   logic [7:0] quietRun_q;
   always_ff @(posedge clk) begin
      if (reset || rx_serial_pos != $past(rx_serial_pos))
         quietRun_q <= 8'h00;
      else if (quietRun_q != 8'hff)
         quietRun_q <= quietRun_q + 8'h01;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_rd_idle_zero: assert property (
      !attrRead |=> attrRdData == 8'h00) else $error("stale read data");
   a_wr_swing: assert property (
      attrWrite && attrAddr == `SCLC_OFS_SWING |=>
      txSwing == $past(attrWrData)) else $error("swing write lost");
   a_wr_equal: assert property (
      attrWrite && attrAddr == `SCLC_OFS_EQUALIZER |=>
      rx_equalizer_setting == $past(attrWrData)) else $error("eq lost");
   a_tx_pair: assert property (
      tx_serial_neg == !tx_serial_pos) else $error("tx pair equal");
   a_forced_ref: assert property (
      rx_lock_source_select |=> !rxLockedToData) else $error("not forced");
   a_valid_gap: assert property (
      rxValid |=> !rxValid [*8]) else $error("word pulses too close");
   a_loss_bound: assert property (
      quietRun_q > MISS_LIMIT + 3 |-> !rxLockedToData)
      else $error("lock kept without transitions");
   a_lock_cause: assert property (
      $rose(rxLockedToData) |-> quietRun_q < 8'h04 &&
      !$past(rx_lock_source_select)) else $error("lock without data");

   cover property (rxValid);
   cover property ($rose(rxLockedToData));
   cover property (attrRead ##1 attrRdData != 8'h00);
endmodule

bind sclc_top sclc_top_props #(.MISS_LIMIT(MISS_LIMIT)) sclc_top_props_inst (
   .clk, .reset, .attrAddr, .attrWrData, .attrWrite, .attrRead,
   .attrRdData, .txSwing, .rx_equalizer_setting, .rx_lock_source_select,
   .rxValid, .rxLockedToData, .tx_serial_pos, .tx_serial_neg,
   .rx_serial_pos);

`default_nettype wire

// file: sim/sclc_link_partner.sv
// sclc_link_partner.sv: far-end transmitter driving the receive pair.
// assumes it shares clk with the block, one bit per edge.
`default_nettype none

module sclc_link_partner (
   // timing and control
   input  wire logic clk,
   input  wire logic hold,
   // serial pair
   output logic      rx_serial_pos,
   output logic      rx_serial_neg
);
   logic lineBit_q = 1'b0;
   // a transition every bit: balanced, dense enough to lock quickly
   always @(posedge clk) begin
      if (!hold)
         lineBit_q <= !lineBit_q;
   end
   // hold gives a run with no transitions; the bench sets its length
   assign rx_serial_pos = lineBit_q;
   assign rx_serial_neg = !lineBit_q;
endmodule

`default_nettype wire

// file: sim/test_sclc_top.sv
// test_sclc_top.sv: self-checking bench of sclc_top.
// assumes package, checker and link partner are compiled first.
`default_nettype none

module test_sclc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk;
   logic        reset = 1'b1;
   logic [2:0]  modeSelect = 3'h0;
   logic [7:0]  cfgSwing = 8'h31;
   logic [7:0]  cfgEmphasis = 8'h42;
   logic [7:0]  cfgEqualizer = 8'h53;
   logic [3:0]  attrAddr = 4'h0;
   logic [7:0]  attrWrData = 8'h00;
   logic        attrWrite = 1'b0;
   logic        attrRead = 1'b0;
   logic [7:0]  attrRdData, txSwing, txEmphasis, rx_equalizer_setting;
   logic [39:0] txData = 40'h0;
   logic        txValid = 1'b0;
   logic        tx_invert_select = 1'b0;
   logic        rx_lock_source_select = 1'b0;
   logic        hold = 1'b1;
   logic [39:0] rxData;
   logic        txReady, rxValid, rx_recovered_clock, rxLockedToData;
   logic        tx_serial_pos, tx_serial_neg, rx_serial_pos, rx_serial_neg;
   int          badCount = 0;
   int          nTests = 0;
   int          fac [5] = '{10, 16, 20, 32, 40};

   sclc_top #(.LOCK_TRANSITIONS(20), .MISS_LIMIT(5)) sclc_top_inst (
      .clk, .reset, .modeSelect, .cfgSwing, .cfgEmphasis, .cfgEqualizer,
      .attrAddr, .attrWrData, .attrWrite, .attrRead, .attrRdData,
      .txSwing, .txEmphasis, .rx_equalizer_setting, .txData, .txValid,
      .txReady, .tx_invert_select, .rx_lock_source_select, .rxData,
      .rxValid, .rx_recovered_clock, .rxLockedToData, .tx_serial_pos,
      .tx_serial_neg, .rx_serial_pos, .rx_serial_neg);
   sclc_link_partner sclc_link_partner_inst (
      .clk, .hold, .rx_serial_pos, .rx_serial_neg);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [39:0] seen, exp);
      nTests++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (badCount == 0 && nTests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      attrAddr <= a;
      attrWrData <= d;
      attrWrite <= 1'b1;
      @(posedge clk);
      attrWrite <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      attrAddr <= a;
      attrRead <= 1'b1;
      @(posedge clk);
      attrRead <= 1'b0;
      @(negedge clk);
      chk("read data", 40'(attrRdData), 40'(exp));
      @(posedge clk);
   endtask

   // idle line sits at inv; the word's bit 0 is 1 and marks its start
   task automatic sendWord(input int f, input logic inv);
      logic [39:0] w;
      logic [39:0] got;
      int          n;
      w = 40'h5a_c3f0_9e6b & ((40'h1 << f) - 40'h1);
      got = 40'h0;
      n = 0;
      txData <= w;
      txValid <= 1'b1;
      @(posedge clk);
      txValid <= 1'b0;
      @(negedge clk);
      while (tx_serial_pos === inv && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200) begin
         badCount++;
         conclude();
      end
      for (int i = 0; i < f; i++) begin
         got[i] = tx_serial_pos ^ inv;
         @(negedge clk);
      end
      chk("serial word", got, w);
      @(posedge clk);
   endtask

   task automatic waitLock();
      int n;
      n = 0;
      while (rxLockedToData !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      chk("lock", 40'(rxLockedToData), 40'h1);
      if (n == 300)
         conclude();
      @(posedge clk);
   endtask

   task automatic nextValid(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rxValid !== 1'b1 && n < 100);
      if (n == 100) begin
         badCount++;
         conclude();
      end
   endtask

   task automatic tReset();
      @(negedge clk);
      chk("swing", 40'(txSwing), 40'h31);
      chk("emphasis", 40'(txEmphasis), 40'h42);
      chk("equalizer", 40'(rx_equalizer_setting), 40'h53);
      chk("ready", 40'(txReady), 40'h1);
      @(posedge clk);
   endtask

   task automatic tTx();
      for (int m = 0; m < 5; m++) begin
         modeSelect <= 3'(m);
         repeat (45) @(posedge clk);
         sendWord(fac[m], 1'b0);
      end
      tx_invert_select <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("pin pre", 40'(tx_serial_pos), 40'h0);
      @(negedge clk);
      chk("pin inv", 40'(tx_serial_pos), 40'h1);
      @(posedge clk);
      sendWord(40, 1'b1);
      tx_invert_select <= 1'b0;
   endtask

   task automatic tAttr();
      for (int a = 0; a < 4; a++) begin
         wr(4'(a), 8'h5a + 8'(a));
         rd(4'(a), 8'h5a + 8'(a));
      end
      wr(4'h4, 8'hff);
      wr(4'hf, 8'hff);
      rd(4'hf, 8'h00);
      @(negedge clk);
      chk("swing", 40'(txSwing), 40'h5a);
      chk("emphasis", 40'(txEmphasis), 40'h5b);
      chk("equalizer", 40'(rx_equalizer_setting), 40'h5c);
      @(posedge clk);
      wr(4'h3, 8'h00);
   endtask

   task automatic tLock();
      int          n;
      int          h;
      logic [39:0] w;
      h = 0;
      hold <= 1'b0;
      waitLock();
      rd(4'h4, 8'h01);
      nextValid(n);
      nextValid(n);
      chk("period", 40'(n), 40'd10);
      repeat (10) begin
         @(negedge clk);
         h += int'(rx_recovered_clock === 1'b1);
      end
      chk("clock high", 40'(h), 40'd5);
      n = int'(rxData === 40'h155 || rxData === 40'h2aa);
      chk("word", 40'(n), 40'h1);
      w = rxData;
      @(posedge clk);
      wr(4'h3, 8'h01);
      nextValid(n);
      nextValid(n);
      chk("rx swap", rxData, w ^ 40'h3ff);
      @(posedge clk);
      wr(4'h3, 8'h00);
      @(posedge clk);
      hold <= 1'b1;
      repeat (4) @(negedge clk);
      chk("lock held", 40'(rxLockedToData), 40'h1);
      repeat (8) @(negedge clk);
      chk("lock lost", 40'(rxLockedToData), 40'h0);
      @(posedge clk);
      hold <= 1'b0;
      waitLock();
      rx_lock_source_select <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("forced", 40'(rxLockedToData), 40'h0);
      nextValid(n);
      nextValid(n);
      chk("local period", 40'(n), 40'd10);
      chk("still forced", 40'(rxLockedToData), 40'h0);
      @(posedge clk);
      rd(4'h4, 8'h04);
      rx_lock_source_select <= 1'b0;
   endtask

   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      tReset();
      tTx();
      // second reset puts mode back to the shortest word cleanly
      reset <= 1'b1;
      modeSelect <= 3'h0;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      tAttr();
      tLock();
      conclude();
   end
endmodule

`default_nettype wire
